// ---- ifec_defs.svh ----
`ifndef IFEC_DEFS_SVH
`define IFEC_DEFS_SVH
// ==========================================================================
// Register byte offsets.
`define IFEC_OFS_CTRL2     12'h000
`define IFEC_OFS_FLAG0     12'h040
`define IFEC_OFS_ENAB0     12'h080
`define IFEC_OFS_HOLD      12'h0c0
// ==========================================================================
// Field positions.
`define IFEC_ALT_BIT       15
`define IFEC_HOLD_BIT      14
`define IFEC_EDGE_LSB      0
// ==========================================================================
// Counts and reset values.
`define IFEC_NUM_VEC       118
`define IFEC_NUM_REG       8
`define IFEC_NUM_EXT       5
`define IFEC_TOP_MASK      16'h003f
`define IFEC_RST_16        16'h0000
`endif

// ---- ifec_pkg.sv ----
package ifec_pkg;
	// Response codes of the register bus.
	typedef enum logic [1:0]
	{
		IFEC_OKAY   = 2'b00,
		IFEC_SLVERR = 2'b10
	} ifec_resp_t;

	// Write slot of the bus slave, address and data caught independently.
	typedef struct packed
	{
		logic        aw_ok;
		logic [11:0] awaddr;
		logic        w_ok;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
	} ifec_wslot_t;
endpackage

// ---- ifec_top.sv ----
// Summary of operation
// - Alternate bit selects alternate vector table.
// - Read-only bit shows timed disable active.
// - Per-pin polarity: one falling, zero rising.
// - Flag bit x reports vector 16n+x.
// - Flag registers 0-6 read/write, reset zero.
// - Flag register 7 bits 5-0, rest zero.
// - Enable bit x enables vector 16n+x.
// - Enable registers 0-6 plus register 7.
`timescale 1ns/1ps
`include "ifec_defs.svh"
`default_nettype none
module ifec_top
#(
	parameter int NUM_VEC = `IFEC_NUM_VEC
)
(
	// Clock and reset.
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// Write address channel.
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [11:0]           s_axi_awaddr,
	// Write data channel.
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	// Write response channel.
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	output ifec_pkg::ifec_resp_t       s_axi_bresp,
	// Read address channel.
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	input  wire logic [11:0]           s_axi_araddr,
	// Read data channel.
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	output logic [31:0]                s_axi_rdata,
	output ifec_pkg::ifec_resp_t       s_axi_rresp,
	// Interrupt sources, one level per vector and five external pins.
	input  wire logic [NUM_VEC-1:0]    src_req,
	input  wire logic [4:0]            ext_irq_pin,
	// Toward the core.
	input  wire logic                  timed_hold_in,
	output logic [NUM_VEC-1:0]         pend_vec,
	output logic                       alt_table_select,
	output logic                       timed_irq_hold_active
);
	import ifec_pkg::*;

	localparam int NREG = `IFEC_NUM_REG;

	// Refuse at elaboration any vector count other than the one that the
	// register map, the read packing and the checks below are laid out for.
	if (NUM_VEC != `IFEC_NUM_VEC)
	begin
		$error("NUM_VEC must equal the implemented vector count.");
	end

	// ======================================================================
	// Register state.
	logic [NUM_VEC-1:0] flag_ff, nxt_flag;
	logic [NUM_VEC-1:0] enab_ff, nxt_enab;
	logic               alt_ff;
	logic [4:0]         edge_sel_ff;
	logic [NUM_VEC-1:0] src_ff;
	logic [4:0]         pin_s1_ff, pin_s2_ff, pin_s3_ff;
	logic [2:0]         warm_ff;
	logic               hold_s1_ff, hold_s2_ff;
	ifec_wslot_t        ws_ff;
	logic               bvalid_ff;
	ifec_resp_t         bresp_ff;
	logic               rvalid_ff;
	logic [31:0]        rdata_ff;
	ifec_resp_t         rresp_ff;

	// Map a byte address to a register group; returns index and hit flag.
	function automatic logic [4:0] dec_addr(input logic [11:0] a, input logic [11:0] base);
		logic [11:0] d;
		d = a - base;
		dec_addr = {((a >= base) && (d[11:2] < 10'(NREG)) && (a[1:0] == 2'b00)), d[5:2]};
	endfunction

	// ======================================================================
	// Write decode. Only the low half-word lanes matter; the registers are 16 bits.
	wire         wr_fire  = ws_ff.aw_ok & ws_ff.w_ok & ~bvalid_ff;
	wire [4:0]   wf_dec   = dec_addr(ws_ff.awaddr, `IFEC_OFS_FLAG0);
	wire [4:0]   we_dec   = dec_addr(ws_ff.awaddr, `IFEC_OFS_ENAB0);
	wire         wr_ctrl  = (ws_ff.awaddr == `IFEC_OFS_CTRL2);
	wire         wr_hold  = (ws_ff.awaddr == `IFEC_OFS_HOLD);
	wire         wr_hit   = wf_dec[4] | we_dec[4] | wr_ctrl | wr_hold;
	wire [15:0]  wmask    = {{8{ws_ff.wstrb[1]}}, {8{ws_ff.wstrb[0]}}};
	wire [15:0]  wval     = ws_ff.wdata[15:0];

	// Edge detectors look at the second and third stages, never the first.
	wire [4:0]   pin_rise = pin_s2_ff & ~pin_s3_ff;
	wire [4:0]   pin_fall = ~pin_s2_ff & pin_s3_ff;
	wire [4:0]   ext_sel  = (edge_sel_ff & pin_fall) | (~edge_sel_ff & pin_rise);
	// The stages leave reset low, so a pin that idles high would look like a
	// rising edge while they fill. Pin events are held off until the third
	// stage carries a real sample; an edge right at reset release is lost.
	wire [4:0]   ext_evt  = warm_ff[2] ? ext_sel : 5'h00;
	wire [NUM_VEC-1:0] src_evt = src_req & ~src_ff;

	// Flag and enable next values. A source event in the same cycle as a
	// software clear wins, so no request is lost.
	always_comb
	begin
		nxt_flag = flag_ff;
		nxt_enab = enab_ff;
		for (int r = 0; r < NREG; r++)
		begin
			for (int b = 0; b < 16; b++)
			begin
				if (r * 16 + b < NUM_VEC)
				begin
					if (wr_fire && wf_dec[4] && wf_dec[3:0] == 4'(r) && wmask[b])
						nxt_flag[r * 16 + b] = wval[b];
					if (wr_fire && we_dec[4] && we_dec[3:0] == 4'(r) && wmask[b])
						nxt_enab[r * 16 + b] = wval[b];
				end
			end
		end
		nxt_flag = nxt_flag | src_evt;
		nxt_flag[4:0] = nxt_flag[4:0] | ext_evt;
	end

	// ======================================================================
	// Source and pin sampling, flags and enables.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			flag_ff     <= '0;
			enab_ff     <= '0;
			src_ff      <= '0;
			pin_s1_ff   <= '0;
			pin_s2_ff   <= '0;
			pin_s3_ff   <= '0;
			warm_ff     <= 3'h0;
			hold_s1_ff  <= 1'b0;
			hold_s2_ff  <= 1'b0;
		end
		else
		begin
			flag_ff     <= nxt_flag;
			enab_ff     <= nxt_enab;
			src_ff      <= src_req;
			pin_s1_ff   <= ext_irq_pin;
			pin_s2_ff   <= pin_s1_ff;
			pin_s3_ff   <= pin_s2_ff;
			warm_ff     <= {warm_ff[1:0], 1'b1};
			hold_s1_ff  <= timed_hold_in;
			hold_s2_ff  <= hold_s1_ff;
		end
	end

	// Control register two: table select and edge polarities.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			alt_ff      <= 1'b0;
			edge_sel_ff <= 5'h00;
		end
		else if (wr_fire && wr_ctrl)
		begin
			if (wmask[`IFEC_ALT_BIT])
				alt_ff <= wval[`IFEC_ALT_BIT];
			if (wmask[0])
				edge_sel_ff <= wval[`IFEC_EDGE_LSB +: 5];
		end
	end

	// ======================================================================
	// Write channels: address and data are taken in either order, one
	// write in flight; the response follows once both are held.
	assign s_axi_awready = ~ws_ff.aw_ok;
	assign s_axi_wready  = ~ws_ff.w_ok;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ws_ff     <= '0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= IFEC_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && !ws_ff.aw_ok)
			begin
				ws_ff.aw_ok  <= 1'b1;
				ws_ff.awaddr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !ws_ff.w_ok)
			begin
				ws_ff.w_ok  <= 1'b1;
				ws_ff.wdata <= s_axi_wdata;
				ws_ff.wstrb <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= wr_hit ? IFEC_OKAY : IFEC_SLVERR;
			end
			else if (bvalid_ff && s_axi_bready)
			begin
				bvalid_ff   <= 1'b0;
				ws_ff.aw_ok <= 1'b0;
				ws_ff.w_ok  <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Read path. Unimplemented bits and upper lanes read as zero.
	wire [4:0]  rf_dec  = dec_addr(s_axi_araddr, `IFEC_OFS_FLAG0);
	wire [4:0]  re_dec  = dec_addr(s_axi_araddr, `IFEC_OFS_ENAB0);
	wire [127:0] flag_w = 128'(flag_ff);
	wire [127:0] enab_w = 128'(enab_ff);
	wire [15:0] ctrl_rd = {alt_ff, hold_s2_ff, 9'h000, edge_sel_ff};
	wire [15:0] flag_rd = flag_w[rf_dec[3:0] * 16 +: 16];
	wire [15:0] enab_rd = enab_w[re_dec[3:0] * 16 +: 16];
	wire        rd_hit  = rf_dec[4] | re_dec[4] | (s_axi_araddr == `IFEC_OFS_CTRL2);
	wire [15:0] rd_val  = rf_dec[4] ? flag_rd :
	                      re_dec[4] ? enab_rd :
	                      (s_axi_araddr == `IFEC_OFS_CTRL2) ? ctrl_rd : `IFEC_RST_16;

	assign s_axi_arready = ~rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= IFEC_OKAY;
		end
		else if (s_axi_arvalid && !rvalid_ff)
		begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= {16'h0000, rd_val};
			rresp_ff  <= rd_hit ? IFEC_OKAY : IFEC_SLVERR;
		end
		else if (rvalid_ff && s_axi_rready)
			rvalid_ff <= 1'b0;
	end

	// ======================================================================
	// Toward the core.
	assign pend_vec              = flag_ff & enab_ff;
	assign alt_table_select      = alt_ff;
	assign timed_irq_hold_active = hold_s2_ff;

	// ======================================================================
	// Checks. Each one watches the vectors, pins and registers that the
	// bench really drives, so that none of them passes merely because its
	// trigger never comes.
	a_pend_gating: assert property (@(posedge aclk) disable iff (!aresetn)
		(!enab_ff[117] && !(wr_fire && we_dec[4])) |=> !pend_vec[117])
		else $error("Disabled vector forwarded.");
	a_src_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		(src_req[117] && !src_ff[117]) |=> flag_ff[117]) else $error("Source edge lost.");
	a_rise_sets_ext: assert property (@(posedge aclk) disable iff (!aresetn)
		(warm_ff[2] && !edge_sel_ff[2] && pin_s2_ff[2] && !pin_s3_ff[2]) |=> flag_ff[2])
		else $error("Rising edge lost.");
	a_fall_sets_ext: assert property (@(posedge aclk) disable iff (!aresetn)
		(warm_ff[2] && edge_sel_ff[2] && !pin_s2_ff[2] && pin_s3_ff[2]) |=> flag_ff[2])
		else $error("Falling edge lost.");
	a_flag_holds: assert property (@(posedge aclk) disable iff (!aresetn)
		(flag_ff[50] && !wr_fire) |=> flag_ff[50]) else $error("Flag dropped.");
	a_alt_output: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_fire && wr_ctrl && wmask[15]) |=> alt_table_select == $past(wval[15]))
		else $error("Table select not updated.");
	a_hold_follow: assert property (@(posedge aclk) disable iff (!aresetn)
		timed_hold_in [*3] |-> timed_irq_hold_active) else $error("Hold status stale.");
	a_hold_readonly: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_fire && wr_ctrl) |=> timed_irq_hold_active == $past(hold_s1_ff))
		else $error("Hold status written.");
	a_edge_write: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_fire && wr_ctrl && wmask[0]) |=> edge_sel_ff == $past(wval[4:0]))
		else $error("Polarity write lost.");
	a_top_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && !rvalid_ff && rf_dec[4] && rf_dec[3:0] == 4'd7)
		|=> (s_axi_rdata[15:6] == 10'h000)) else $error("Flag seven upper bits set.");
	a_enab_write: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_fire && we_dec[4] && we_dec[3:0] == 4'd0 && wmask[0])
		|=> enab_ff[0] == $past(wval[0]))
		else $error("Enable write lost.");
	a_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_fire && wf_dec[4] && wf_dec[3:0] == 4'd1 && wmask[2] && !wval[2]
		&& !src_evt[18]) |=> !flag_ff[18])
		else $error("Flag clear lost.");
endmodule
`default_nettype wire

// ---- ifec_src_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Peripheral request sources: a fire raises one vector's level for a span.
module ifec_src_model
(
	// Clock and reset.
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Command from the bench.
	input  wire logic         fire,
	input  wire logic [6:0]   vec,
	input  wire logic [1:0]   span,
	// Request levels toward the controller.
	output logic [117:0]      src_req
);
	logic [2:0] left_ff;
	logic [6:0] vec_ff;
	// A slow peripheral holds its level for several cycles, so only the rise may count.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			left_ff <= 3'h0;
		else if (fire)
			left_ff <= {1'b0, span} + 3'h1;
		else if (left_ff != 3'h0)
			left_ff <= left_ff - 3'h1;
		if (fire)
			vec_ff <= vec;
	end
	// Only the selected vector is driven high while the span runs.
	assign src_req = (left_ff != 3'h0) ? (118'h1 << vec_ff) : 118'h0;
endmodule
`default_nettype wire

// ---- ifec_top_test.sv ----
`timescale 1ns/1ps
`include "ifec_defs.svh"
`default_nettype none
module ifec_top_test;
	import ifec_pkg::*;
	// ==========================================================================
	// Bench signals.
	logic         aclk, aresetn, awv, awr, wv, wr_, bv, br, arv, arr, rv, rr;
	logic         fire, hold, alt, hold_out;
	logic [11:0]  awa, ara;
	logic [31:0]  wd, rdat;
	logic [4:0]   pins;
	logic [3:0]   strb;
	logic [6:0]   vec;
	logic [1:0]   span;
	logic [117:0] src, pend;
	ifec_resp_t   bresp, rresp;
	int           bad_count, tests_run;
	ifec_top ifec_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr_),
		.s_axi_wdata(wd), .s_axi_wstrb(strb), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
		.src_req(src), .ext_irq_pin(pins), .timed_hold_in(hold), .pend_vec(pend),
		.alt_table_select(alt), .timed_irq_hold_active(hold_out));
	ifec_src_model ifec_src_model_inst (.aclk(aclk), .aresetn(aresetn), .fire(fire),
		.vec(vec), .span(span), .src_req(src));
	// ==========================================================================
	// Shared tasks.
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// Address and data are offered together and each released once taken.
	task automatic wr(input logic [11:0] a, input logic [31:0] v, input ifec_resp_t e);
		@(posedge aclk);
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= v;
		br <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wr_) wv <= 1'b0;
			if (bv) break;
		end
		br <= 1'b0;
		chk("bresp", 32'(e), 32'(bresp));
	endtask
	task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
		@(posedge aclk);
		arv <= 1'b1;
		ara <= a;
		rr <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (arv && arr) arv <= 1'b0;
			if (rv) break;
		end
		rr <= 1'b0;
		chk(n, e, rdat);
		chk("rresp", 32'(IFEC_OKAY), 32'(rresp));
	endtask
	task automatic pins_to(input logic [4:0] p);
		@(posedge aclk);
		pins <= p;
		repeat (6) @(posedge aclk);
	endtask
	// ==========================================================================
	// Scenarios.
	task automatic t_regs;
		for (int n = 0; n < 8; n++)
		begin
			rchk("flag_rst", `IFEC_OFS_FLAG0 + 12'(4 * n), 32'h0);
			rchk("enab_rst", `IFEC_OFS_ENAB0 + 12'(4 * n), 32'h0);
			wr(`IFEC_OFS_FLAG0 + 12'(4 * n), 32'hffff, IFEC_OKAY);
			wr(`IFEC_OFS_ENAB0 + 12'(4 * n), 32'hffff, IFEC_OKAY);
			rchk("flag", `IFEC_OFS_FLAG0 + 12'(4 * n), n < 7 ? 32'hffff : 32'h3f);
			rchk("enab", `IFEC_OFS_ENAB0 + 12'(4 * n), n < 7 ? 32'hffff : 32'h3f);
			wr(`IFEC_OFS_FLAG0 + 12'(4 * n), 32'h0, IFEC_OKAY);
			wr(`IFEC_OFS_ENAB0 + 12'(4 * n), 32'h0, IFEC_OKAY);
		end
	endtask
	task automatic t_ctrl;
		rchk("ctrl_rst", `IFEC_OFS_CTRL2, 32'h0);
		wr(`IFEC_OFS_CTRL2, 32'hffff, IFEC_OKAY);
		rchk("ctrl", `IFEC_OFS_CTRL2, 32'h801f);
		chk("alt", 32'h1, 32'(alt));
		hold <= 1'b1;
		repeat (4) @(posedge aclk);
		chk("hold", 32'h1, 32'(hold_out));
		rchk("ctrl_hold", `IFEC_OFS_CTRL2, 32'hc01f);
		hold <= 1'b0;
		wr(`IFEC_OFS_CTRL2, 32'h0, IFEC_OKAY);
		@(negedge aclk);
		chk("alt_off", 32'h0, 32'(alt));
	endtask
	// A slow source on vector 117 sets its flag while disabled; enabling forwards it.
	task automatic t_vec;
		@(posedge aclk);
		fire <= 1'b1;
		vec <= 7'd117;
		span <= 2'd3;
		@(posedge aclk);
		fire <= 1'b0;
		repeat (6) @(posedge aclk);
		rchk("flag7", `IFEC_OFS_FLAG0 + 12'h1c, 32'h20);
		chk("pend_off", 32'h0, 32'(|pend));
		wr(`IFEC_OFS_ENAB0 + 12'h1c, 32'h20, IFEC_OKAY);
		@(negedge aclk);
		chk("pend", 32'h1, 32'(pend[117]));
		chk("pend_rest", 32'h0, 32'(|pend[116:0]));
		wr(`IFEC_OFS_FLAG0 + 12'h1c, 32'h0, IFEC_OKAY);
		@(negedge aclk);
		chk("pend_clr", 32'h0, 32'(|pend));
		wr(`IFEC_OFS_ENAB0 + 12'h1c, 32'h0, IFEC_OKAY);
	endtask
	// Pin 2 with rising and then falling selection.
	task automatic t_edge;
		pins_to(5'h04);
		rchk("rise", `IFEC_OFS_FLAG0, 32'h4);
		wr(`IFEC_OFS_FLAG0, 32'h0, IFEC_OKAY);
		pins_to(5'h00);
		rchk("fall_ign", `IFEC_OFS_FLAG0, 32'h0);
		wr(`IFEC_OFS_CTRL2, 32'h4, IFEC_OKAY);
		pins_to(5'h04);
		rchk("rise_ign", `IFEC_OFS_FLAG0, 32'h0);
		pins_to(5'h00);
		rchk("fall", `IFEC_OFS_FLAG0, 32'h4);
		wr(`IFEC_OFS_FLAG0, 32'h0, IFEC_OKAY);
		wr(`IFEC_OFS_CTRL2, 32'h0, IFEC_OKAY);
	endtask
	task automatic t_unmapped;
		wr(12'h100, 32'hffff, IFEC_SLVERR);
		@(posedge aclk);
		arv <= 1'b1;
		ara <= 12'h100;
		rr <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (arv && arr) arv <= 1'b0;
			if (rv) break;
		end
		rr <= 1'b0;
		chk("unm_data", 32'h0, rdat);
		chk("unm_resp", 32'(IFEC_SLVERR), 32'(rresp));
	endtask
	// Only the low byte lane is strobed, so the upper byte keeps its value.
	task automatic t_lanes;
		wr(`IFEC_OFS_ENAB0, 32'h5a5a, IFEC_OKAY);
		strb <= 4'h1;
		wr(`IFEC_OFS_ENAB0, 32'hffff, IFEC_OKAY);
		strb <= 4'hf;
		rchk("lanes", `IFEC_OFS_ENAB0, 32'h5aff);
		wr(`IFEC_OFS_ENAB0, 32'h0, IFEC_OKAY);
	endtask
	// A reset in mid-run returns registers and outputs to zero.
	task automatic t_reset;
		wr(`IFEC_OFS_CTRL2, 32'h8001, IFEC_OKAY);
		wr(`IFEC_OFS_FLAG0, 32'h1, IFEC_OKAY);
		wr(`IFEC_OFS_ENAB0, 32'h1, IFEC_OKAY);
		chk("pre_pend", 32'h1, 32'(pend[0]));
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		chk("rst_pend", 32'h0, 32'(|pend));
		chk("rst_alt", 32'h0, 32'(alt));
		rchk("rst_flag", `IFEC_OFS_FLAG0, 32'h0);
		rchk("rst_enab", `IFEC_OFS_ENAB0, 32'h0);
		rchk("rst_ctrl", `IFEC_OFS_CTRL2, 32'h0);
	endtask
	task automatic tally_and_finish;
		if (bad_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ==========================================================================
	// Clock, watchdog and main sequence.
	initial
	begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	initial
	begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		tally_and_finish();
	end
	initial
	begin
		{aresetn, awv, wv, br, arv, rr, fire, hold} = 8'h0;
		{awa, ara, wd, pins, vec, span} = '0;
		strb = 4'hf;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_ctrl();
		t_vec();
		t_edge();
		t_lanes();
		t_reset();
		t_unmapped();
		tally_and_finish();
	end
endmodule
`default_nettype wire
